/* File: hdl/sas_gain.sv */
// Purpose: gain correction of one raw result over a fixed number of clocks
// Assumes: a new start only when not busy
// Notes: coefficient is unsigned with GAIN_FRAC fraction bits, result saturates
`timescale 1ns/10ps
module sas_gain #(
   parameter int W = sas_pkg::RES_W,
   parameter int CYC = sas_pkg::GAIN_CYC,
   parameter int FRAC = sas_pkg::GAIN_FRAC
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // request
   input wire logic start,
   input wire logic [W-1:0] raw,
   input wire logic [W-1:0] coef,
   // answer
   output logic busy,
   output logic done,
   output logic [W-1:0] result
);
   import sas_pkg::*;

   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(CYC);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   logic [CW-1:0] cnt_ff;
   logic signed [2*W:0] prod_ff;
   logic done_ff;
   logic [W-1:0] res_ff;
   logic signed [2*W:0] prod;
   logic signed [2*W:0] shifted;
   logic ovf;
   logic [W-1:0] sat;

   assign prod = (2*W+1)'($signed(raw) * $signed({1'b0, coef}));
   assign shifted = prod_ff >>> FRAC;
   assign ovf = !((&shifted[2*W:W-1]) || !(|shifted[2*W:W-1]));
   assign sat = shifted[2*W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_ff <= '0;
         prod_ff <= '0;
         done_ff <= 1'b0;
         res_ff <= '0;
      end else begin
         done_ff <= (cnt_ff == CNT_ONE);
         if (start) begin
            cnt_ff <= CNT_LOAD; // [R2]
            prod_ff <= prod;
         end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - CNT_ONE;
         end
         if (cnt_ff == CNT_ONE) begin
            res_ff <= ovf ? sat : shifted[W-1:0];
         end
      end
   end

   assign busy = (cnt_ff != '0);
   assign done = done_ff;
   assign result = res_ff;
endmodule

/* File: hdl/sas_pkg.sv */
// Purpose: constants, register map and types of the scan sequencer
// Assumes: one clock, conversion clock equals the peripheral clock
// Notes: register offsets are byte addresses on the plain register port
//
// What this block does
// [R1] exactly 18 clocks of successive approximation
// [R2] every raw result gain corrected, 10 clocks
// [R3] correction overlaps next channel's sampling
// [R4] sampling lasts the programmed sample time setting; a setting of 0 samples for 1 clock
// [R5] software waits settling or lengthens sample time
// [R6] start on software, event link, or pin
// [R7] convert enabled channels, lowest number first
// [R8] corrected result stored in channel's own register
// [R9] scan end interrupt after last channel corrected
// [R10] start bit high during scan, self-cleared
// [R11] peripheral clock kept at or below 32 MHz
// [R12] software selects differential or single-ended input
// [R13] invert odd single-ended results when enabled
// [R14] sampling timed by down counter from setting
// [R15] triggers ignored while the start bit is set
package sas_pkg;
   // register offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SEL_LO = 8'h04;
   localparam logic [7:0] OFF_SEL_HI = 8'h08;
   localparam logic [7:0] OFF_STIME = 8'h0c;
   localparam logic [7:0] OFF_EXT = 8'h10;
   localparam logic [7:0] OFF_GAIN = 8'h14;
   localparam logic [7:0] OFF_ISTAT = 8'h18;
   localparam logic [7:0] OFF_IMASK = 8'h1c;
   localparam logic [7:0] OFF_RES = 8'h80;
   // control fields
   localparam int CTRL_START = 0;
   localparam int CTRL_DIFF = 1;
   localparam int CTRL_ELC_EN = 2;
   localparam int CTRL_PIN_EN = 3;
   localparam int EXT_INV = 0;
   // interrupt status fields
   localparam int IRQ_SCAN_END = 0;
   localparam int IRQ_RESULT = 1;
   localparam int IRQ_W = 2;
   // sizes
   localparam int NCH = 32;
   localparam int CH_W = 5;
   localparam int RES_W = 16;
   localparam int STIME_W = 8;
   localparam int GAIN_FRAC = 14;
   // timing
   localparam int CLK_MHZ = 10;
   localparam int APPROX_CYC = 18;
   localparam int GAIN_CYC = 10;
   localparam int SAMPLE_MIN_NS = 250;
   localparam int SETTLE_MAX_NS = 1000;
   localparam int SAMPLE_MIN_CYC = (SAMPLE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = (SETTLE_MAX_NS * CLK_MHZ) / 1000;
   // reset values and first trial code
   localparam logic [STIME_W-1:0] STIME_RST = STIME_W'(SAMPLE_MIN_CYC + SETTLE_CYC);
   localparam logic [RES_W-1:0] GAIN_RST = 16'h4000;
   localparam logic [RES_W-1:0] SAR_MSB = 16'h8000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_NEXT,
      ST_SAMPLE,
      ST_APPROX,
      ST_DRAIN
   } sas_state_t;
endpackage

/* File: hdl/sas_seq.sv */
// Purpose: scan sequencer of a 16-bit successive approximation converter
// Assumes: comparator answers within one clock of a new trial code
// Notes: one gain correction in flight at most, since approximation is longer
`timescale 1ns/10ps
module sas_seq (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // start triggers
   input wire logic event_link_trigger,
   input wire logic ext_trig_pin,
   // analog front end
   input wire logic comp_hi,
   output logic sample_on,
   output logic [sas_pkg::CH_W-1:0] mux_ch,
   output logic diff_mode,
   output logic [sas_pkg::RES_W-1:0] dac_code,
   // interrupt
   output logic scan_end_interrupt
);
   import sas_pkg::*;

   localparam logic [4:0] ACNT_LAST = 5'(APPROX_CYC - 1);
   localparam logic [4:0] ACNT_ONE = 5'(1);
   localparam logic [4:0] ACNT_BITS = 5'(RES_W);
   localparam logic [STIME_W-1:0] SCNT_ONE = STIME_W'(1);

   //////////////////////////////////////////////////////////////////////
   // registers
   logic start_ff;
   logic diff_ff;
   logic elc_en_ff;
   logic pin_en_ff;
   logic [15:0] sel_lo_ff;
   logic [15:0] sel_hi_ff;
   logic [STIME_W-1:0] stime_ff;
   logic inv_ff;
   logic [RES_W-1:0] coef_ff;
   logic [IRQ_W-1:0] stat_ff;
   logic [IRQ_W-1:0] mask_ff;
   logic [RES_W-1:0] res_ff [NCH];
   logic [31:0] rdata_ff;
   logic irq_ff;

   // sequencer state
   sas_state_t state_ff;
   logic [NCH-1:0] pend_ff;
   logic [STIME_W-1:0] scnt_ff;
   logic [4:0] acnt_ff;
   logic [RES_W-1:0] code_ff;
   logic [CH_W-1:0] cur_ff;
   logic sample_on_ff;
   logic [CH_W-1:0] gch_ff;
   logic ginv_ff;

   // pin synchroniser
   logic pin_s1_ff;
   logic pin_s2_ff;
   logic pin_s3_ff;

   //////////////////////////////////////////////////////////////////////
   // register decode
   wire wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
   wire wr_sel_lo = reg_wr && (reg_addr == OFF_SEL_LO);
   wire wr_sel_hi = reg_wr && (reg_addr == OFF_SEL_HI);
   wire wr_stime = reg_wr && (reg_addr == OFF_STIME);
   wire wr_ext = reg_wr && (reg_addr == OFF_EXT);
   wire wr_gain = reg_wr && (reg_addr == OFF_GAIN);
   wire wr_imask = reg_wr && (reg_addr == OFF_IMASK);
   wire rd_istat = reg_rd && (reg_addr == OFF_ISTAT);
   wire is_res = (reg_addr >= OFF_RES);
   wire [CH_W-1:0] res_idx = reg_addr[CH_W+1:2];

   //////////////////////////////////////////////////////////////////////
   // triggers
   wire pin_rise = pin_s2_ff && !pin_s3_ff;
   wire sw_trig = wr_ctrl && reg_wdata[CTRL_START];
   wire elc_trig = elc_en_ff && event_link_trigger;
   wire hw_trig = pin_en_ff && pin_rise;
   wire trig = !start_ff && (sw_trig || elc_trig || hw_trig); // [R6] [R15]

   //////////////////////////////////////////////////////////////////////
   // channel pick and sampling length
   wire [NCH-1:0] sel_all = {sel_hi_ff, sel_lo_ff};
   wire any_pend = |pend_ff;
   logic [CH_W-1:0] low_ch;

   always_comb begin
      low_ch = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (pend_ff[i]) begin
            low_ch = CH_W'(i); // [R7]
         end
      end
   end

   wire [NCH-1:0] low_bit = NCH'(1) << low_ch;
   wire [STIME_W-1:0] samp_len = (stime_ff == '0) ? SCNT_ONE : stime_ff;

   //////////////////////////////////////////////////////////////////////
   // approximation step
   wire [4:0] bit_pos = ACNT_BITS - acnt_ff;
   wire [RES_W-1:0] trial = RES_W'(1) << bit_pos[3:0];
   wire [RES_W-1:0] kept = comp_hi ? code_ff : (code_ff & ~trial);
   wire [RES_W-1:0] stepped = (bit_pos == '0) ? kept : (kept | (trial >> 1));
   wire in_bits = (acnt_ff != '0) && (acnt_ff <= ACNT_BITS);

   // raw code as signed input of gain stage
   wire [RES_W-1:0] raw_diff = {~code_ff[RES_W-1], code_ff[RES_W-2:0]};
   wire [RES_W-1:0] raw_single = {1'b0, code_ff[RES_W-1:1]};
   wire [RES_W-1:0] raw_s = diff_ff ? raw_diff : raw_single; // [R12]

   //////////////////////////////////////////////////////////////////////
   // sequencer
   sas_state_t nxt_state;
   logic [NCH-1:0] nxt_pend;
   logic [STIME_W-1:0] nxt_scnt;
   logic [4:0] nxt_acnt;
   logic [RES_W-1:0] nxt_code;
   logic [CH_W-1:0] nxt_cur;
   logic nxt_sample_on;
   logic g_start;
   logic scan_done;
   logic g_busy;
   logic g_done;
   logic [RES_W-1:0] g_res;

   always_comb begin
      nxt_state = state_ff;
      nxt_pend = pend_ff;
      nxt_scnt = scnt_ff;
      nxt_acnt = acnt_ff;
      nxt_code = code_ff;
      nxt_cur = cur_ff;
      nxt_sample_on = sample_on_ff;
      g_start = 1'b0;
      scan_done = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (trig) begin
               nxt_pend = sel_all; // [R7]
               nxt_state = ST_NEXT;
            end
         end
         ST_NEXT: begin
            if (any_pend) begin
               nxt_cur = low_ch; // [R7]
               nxt_pend = pend_ff & ~low_bit;
               nxt_scnt = samp_len; // [R14]
               nxt_sample_on = 1'b1;
               nxt_state = ST_SAMPLE;
            end else begin
               nxt_state = ST_DRAIN;
            end
         end
         ST_SAMPLE: begin
            if (scnt_ff == SCNT_ONE) begin
               nxt_sample_on = 1'b0; // [R4]
               nxt_acnt = '0;
               nxt_state = ST_APPROX;
            end else begin
               nxt_scnt = scnt_ff - SCNT_ONE; // [R14]
            end
         end
         ST_APPROX: begin
            nxt_acnt = acnt_ff + ACNT_ONE;
            if (acnt_ff == '0) begin
               nxt_code = SAR_MSB;
            end else if (in_bits) begin
               nxt_code = stepped;
            end
            if (acnt_ff == ACNT_LAST) begin
               g_start = 1'b1; // [R1]
               nxt_state = ST_NEXT; // [R3]
            end
         end
         ST_DRAIN: begin
            if (!g_busy) begin
               scan_done = 1'b1; // [R9]
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         pend_ff <= '0;
         scnt_ff <= '0;
         acnt_ff <= '0;
         code_ff <= '0;
         cur_ff <= '0;
         sample_on_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pend_ff <= nxt_pend;
         scnt_ff <= nxt_scnt;
         acnt_ff <= nxt_acnt;
         code_ff <= nxt_code;
         cur_ff <= nxt_cur;
         sample_on_ff <= nxt_sample_on;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // gain correction
   sas_gain #(
      .W(RES_W),
      .CYC(GAIN_CYC),
      .FRAC(GAIN_FRAC)
   ) u_gain (
      .clk(clk),
      .reset_n(reset_n),
      .start(g_start),
      .raw(raw_s),
      .coef(coef_ff),
      .busy(g_busy),
      .done(g_done),
      .result(g_res)
   );

   wire odd_inv = inv_ff && !diff_ff && cur_ff[0];
   wire [RES_W-1:0] store_val = ginv_ff ? ~g_res : g_res; // [R13]

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gch_ff <= '0;
         ginv_ff <= 1'b0;
      end else if (g_start) begin
         gch_ff <= cur_ff;
         ginv_ff <= odd_inv; // [R13]
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < NCH; i++) begin
            res_ff[i] <= '0;
         end
      end else if (g_done) begin
         res_ff[gch_ff] <= store_val; // [R8]
      end
   end

   //////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         start_ff <= 1'b0;
      end else if (trig) begin
         start_ff <= 1'b1; // [R10]
      end else if (scan_done) begin
         start_ff <= 1'b0; // [R10]
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         diff_ff <= 1'b0;
         elc_en_ff <= 1'b0;
         pin_en_ff <= 1'b0;
      end else if (wr_ctrl) begin
         diff_ff <= reg_wdata[CTRL_DIFF]; // [R12]
         elc_en_ff <= reg_wdata[CTRL_ELC_EN];
         pin_en_ff <= reg_wdata[CTRL_PIN_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sel_lo_ff <= '0;
         sel_hi_ff <= '0;
         stime_ff <= STIME_RST;
         inv_ff <= 1'b0;
         coef_ff <= GAIN_RST;
         mask_ff <= '0;
      end else begin
         if (wr_sel_lo) sel_lo_ff <= reg_wdata[15:0];
         if (wr_sel_hi) sel_hi_ff <= reg_wdata[15:0];
         if (wr_stime) stime_ff <= reg_wdata[STIME_W-1:0]; // [R4]
         if (wr_ext) inv_ff <= reg_wdata[EXT_INV];
         if (wr_gain) coef_ff <= reg_wdata[RES_W-1:0];
         if (wr_imask) mask_ff <= reg_wdata[IRQ_W-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // interrupt status, cleared by read, set wins
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] nxt_stat;

   always_comb begin
      ev = '0;
      ev[IRQ_SCAN_END] = scan_done; // [R9]
      ev[IRQ_RESULT] = g_done;
      nxt_stat = (rd_istat ? '0 : stat_ff) | ev;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stat_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         irq_ff <= |(nxt_stat & mask_ff); // [R9]
      end
   end

   //////////////////////////////////////////////////////////////////////
   // read data
   wire [31:0] rd_ctrl = {28'h0, pin_en_ff, elc_en_ff, diff_ff, start_ff}; // [R10]
   wire [31:0] rd_res = {16'h0, res_ff[res_idx]};
   logic [31:0] rd_mux;

   always_comb begin
      case (reg_addr)
         OFF_CTRL: rd_mux = rd_ctrl;
         OFF_SEL_LO: rd_mux = {16'h0, sel_lo_ff};
         OFF_SEL_HI: rd_mux = {16'h0, sel_hi_ff};
         OFF_STIME: rd_mux = {24'h0, stime_ff};
         OFF_EXT: rd_mux = {31'h0, inv_ff};
         OFF_GAIN: rd_mux = {16'h0, coef_ff};
         OFF_ISTAT: rd_mux = {30'h0, stat_ff};
         OFF_IMASK: rd_mux = {30'h0, mask_ff};
         default: rd_mux = is_res ? rd_res : 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= reg_rd ? rd_mux : 32'h0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // trigger pin synchroniser and edge
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
      end else begin
         pin_s1_ff <= ext_trig_pin;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata = rdata_ff;
   assign sample_on = sample_on_ff;
   assign mux_ch = cur_ff;
   assign diff_mode = diff_ff;
   assign dac_code = code_ff;
   assign scan_end_interrupt = irq_ff;
endmodule

/* File: verification/sas_afe_model.sv */
// Purpose: analog front end stand-in, one ideal comparator behind the channel mux
// Assumes: each channel level is given as an unsigned code
// Notes: decides in the same cycle as the trial code
`timescale 1ns/10ps
module sas_afe_model (
   // mux and trial code
   input wire logic [sas_pkg::CH_W-1:0] mux_ch,
   input wire logic [sas_pkg::RES_W-1:0] dac_code,
   // channel levels
   input wire logic [sas_pkg::RES_W-1:0] vin [sas_pkg::NCH],
   // decision
   output logic comp_hi
);
   import sas_pkg::*;
   assign comp_hi = (vin[mux_ch] >= dac_code);
endmodule

/* File: verification/sas_seq_sva.sv */
// Purpose: port-level checks of the scan sequencer
// Assumes: sample time and mask change only between scans
// Notes: gaps of 30 cycles or more count as a new scan
`timescale 1ns/10ps
module sas_seq_chk (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // front end and interrupt
   input wire logic sample_on,
   input wire logic [sas_pkg::CH_W-1:0] mux_ch,
   input wire logic [sas_pkg::RES_W-1:0] dac_code,
   input wire logic scan_end_interrupt
);
   import sas_pkg::*;
   logic [STIME_W-1:0] stime_ff;
   logic [IRQ_W-1:0] mask_ff;
   logic [7:0] hi_cnt_ff;
   logic [5:0] gap_cnt_ff;
   logic [7:0] samp_len;
   assign samp_len = (stime_ff == '0) ? 8'h01 : 8'(stime_ff);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stime_ff <= STIME_RST;
         mask_ff <= '0;
         hi_cnt_ff <= 8'h00;
         gap_cnt_ff <= 6'h3f;
      end else begin
         if (reg_wr && reg_addr == OFF_STIME) stime_ff <= reg_wdata[STIME_W-1:0];
         if (reg_wr && reg_addr == OFF_IMASK) mask_ff <= reg_wdata[IRQ_W-1:0];
         hi_cnt_ff <= sample_on ? hi_cnt_ff + 8'h01 : 8'h00;
         if (sample_on) gap_cnt_ff <= 6'h00;
         else if (gap_cnt_ff != 6'h3f) gap_cnt_ff <= gap_cnt_ff + 6'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_sar_hold;
      $stable(mux_ch) [*8];
   endsequence
   chk_sample_len: assert property ($fell(sample_on) |-> hi_cnt_ff == samp_len)
      else $error("sampling length off");
   chk_sar_gap: assert property ($rose(sample_on) && gap_cnt_ff < 6'd30
      |-> gap_cnt_ff == 6'd19)
      else $error("channel spacing off");
   chk_sar_first: assert property ($fell(sample_on) |=> dac_code == SAR_MSB)
      else $error("first trial code off");
   chk_mux_hold: assert property ($fell(sample_on) |-> s_sar_hold)
      else $error("channel moved during approximation");
   chk_order_up: assert property ($rose(sample_on) && gap_cnt_ff < 6'd30
      |-> mux_ch > $past(mux_ch))
      else $error("channel order not ascending");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   chk_busy_read: assert property (reg_rd && reg_addr == OFF_CTRL && sample_on
      |=> reg_rdata[CTRL_START])
      else $error("start bit low during scan");
   chk_irq_masked: assert property (mask_ff == '0 && $past(mask_ff) == '0
      |-> !scan_end_interrupt)
      else $error("interrupt while masked");
   chk_irq_clear: assert property (reg_rd && reg_addr == OFF_ISTAT
      |-> ##2 !scan_end_interrupt)
      else $error("interrupt stays after status read");
   // last sample end, 18 approx, 10 gain, store, irq
   chk_end_delay: assert property ($rose(scan_end_interrupt) && mask_ff == 2'h1
      |-> $past(sample_on, 30) && !$past(sample_on, 29))
      else $error("scan end timing off");
endmodule
bind sas_seq sas_seq_chk u_sas_seq_chk (
   .clk(clk),
   .reset_n(reset_n),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .sample_on(sample_on),
   .mux_ch(mux_ch),
   .dac_code(dac_code),
   .scan_end_interrupt(scan_end_interrupt)
);

/* File: verification/tb_sar_adc_scan_sequencer.sv */
// Purpose: self-checking bench of the scan sequencer
// Assumes: ideal front end, gain 0x4000 or 0x2000 so no saturation
// Notes: each trigger source drives one scan
`timescale 1ns/10ps
module tb_sar_adc_scan_sequencer;
   import sas_pkg::*;
   logic clk, reset_n, reg_wr, reg_rd, event_link_trigger, ext_trig_pin, comp_hi;
   logic sample_on, diff_mode, scan_end_interrupt, prev_on;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [CH_W-1:0] mux_ch;
   logic [RES_W-1:0] dac_code;
   logic [RES_W-1:0] vin [NCH];
   logic [CH_W-1:0] order_q [$];
   int err_total, tests_run, irq_cnt;
   sas_seq DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .event_link_trigger(event_link_trigger), .ext_trig_pin(ext_trig_pin),
      .comp_hi(comp_hi), .sample_on(sample_on), .mux_ch(mux_ch), .diff_mode(diff_mode),
      .dac_code(dac_code), .scan_end_interrupt(scan_end_interrupt));
   sas_afe_model u_afe (.mux_ch(mux_ch), .dac_code(dac_code), .vin(vin), .comp_hi(comp_hi));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk; // 10 MHz
   end
   always @(negedge clk) begin
      if (sample_on && !prev_on) begin
         order_q.push_back(mux_ch);
      end
      if (scan_end_interrupt) irq_cnt++;
      prev_on = sample_on;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp, what);
   endtask
   task automatic wait_done();
      logic [31:0] v;
      int n;
      n = 0;
      v = 32'h1;
      while (v[CTRL_START] !== 1'b0 && n < 200) begin
         rd(OFF_CTRL, v);
         n++;
      end
      chk({31'h0, n < 200}, 32'h1, "start bit self clear");
   endtask
   task automatic wrap_up();
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdchk(OFF_STIME, {24'h0, STIME_RST}, "sample time reset");
      rdchk(OFF_GAIN, {16'h0, GAIN_RST}, "gain reset");
      wr(8'h40, 32'hffff_ffff);
      rdchk(8'h40, 32'h0, "unmapped read");
      rdchk(OFF_CTRL, 32'h0, "no stray start");
   endtask
   task automatic t_scan_se();
      int base;
      vin[2] <= 16'h9abc;
      vin[5] <= 16'h4321;
      wr(OFF_SEL_LO, 32'h24);
      wr(OFF_EXT, 32'h1);
      wr(OFF_STIME, 32'h4);
      wr(OFF_IMASK, 32'h1);
      base = order_q.size();
      wr(OFF_CTRL, 32'h1);
      rdchk(OFF_CTRL, 32'h1, "start bit in scan");
      wr(OFF_CTRL, 32'h1);
      wait_done();
      chk(32'(order_q.size() - base), 32'd2, "channels sampled");
      chk({27'h0, order_q[base]}, 32'd2, "first channel");
      chk({27'h0, order_q[base + 1]}, 32'd5, "second channel");
      chk({31'h0, scan_end_interrupt}, 32'h1, "irq raised");
      rdchk(OFF_ISTAT, 32'h3, "status");
      @(posedge clk);
      #1 chk({31'h0, scan_end_interrupt}, 32'h0, "irq cleared");
      rdchk(OFF_RES + 8'h08, {16'h0, 16'h9abc >> 1}, "even result");
      rdchk(OFF_RES + 8'h14, {16'h0, ~(16'h4321 >> 1)}, "odd inverted");
   endtask
   task automatic t_scan_diff();
      int base;
      vin[16] <= 16'h2345;
      wr(OFF_SEL_LO, 32'h0);
      wr(OFF_SEL_HI, 32'h1);
      wr(OFF_GAIN, 32'h2000);
      wr(OFF_CTRL, 32'h6);
      @(posedge clk);
      #1 chk({31'h0, diff_mode}, 32'h1, "diff mode");
      base = order_q.size();
      @(posedge clk);
      event_link_trigger <= 1'b1;
      @(posedge clk);
      event_link_trigger <= 1'b0;
      wait_done();
      chk({27'h0, order_q[base]}, 32'd16, "event link scan");
      // signed 0xa345 halved by the coefficient
      rdchk(OFF_RES + 8'h40, {16'h0, 16'hd1a2}, "diff result");
      rdchk(OFF_ISTAT, 32'h3, "status");
   endtask
   task automatic t_scan_pin();
      int base;
      int irq_base;
      vin[0] <= 16'hfffe;
      wr(OFF_SEL_HI, 32'h0);
      wr(OFF_SEL_LO, 32'h1);
      wr(OFF_STIME, 32'h0);
      wr(OFF_IMASK, 32'h0);
      wr(OFF_CTRL, 32'h8);
      repeat (3) @(posedge clk);
      irq_base = irq_cnt;
      base = order_q.size();
      ext_trig_pin <= 1'b1;
      repeat (6) @(posedge clk);
      wait_done();
      chk(32'(order_q.size() - base), 32'd1, "pin scan");
      chk(32'(irq_cnt - irq_base), 32'h0, "masked irq");
      rdchk(OFF_ISTAT, 32'h3, "status");
      rdchk(OFF_RES, {16'h0, 16'h3fff}, "pin result");
      @(posedge clk);
      ext_trig_pin <= 1'b0;
   endtask
   initial begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      event_link_trigger = 1'b0;
      ext_trig_pin = 1'b0;
      err_total = 0;
      tests_run = 0;
      foreach (vin[i]) vin[i] = 16'h0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_scan_se();
      t_scan_diff();
      t_scan_pin();
      wrap_up();
   end
   initial begin
      #(20000 * 100);
      err_total++;
      wrap_up();
   end
endmodule
